//--- sim/tb_tx_buffer_command_parser.sv
// Self-checking bench for the transmit command parser
`timescale 1ns/1ns
module tb_tx_buffer_command_parser
  import tx_cmd_pkg::*;
;
  logic        ref_clk, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, pay_ready, irq;
  logic        pay_last, pay_valid, stat_valid, stat_err, tx_error_flag, tx_buffer_done_flag;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [2:0]  pay_bytes;
  logic [31:0] wb_dat_i, wb_dat_o, pay_data, rd_q;
  logic [15:0] stat_tag, tg, s_tag;
  logic [10:0] sz, s2;
  logic [35:0] ev0;
  logic [35:0] exp_q[$];
  logic [31:0] seed = 32'h24;
  logic [7:0]  ra[4] = '{OFS_STS, OFS_EN, OFS_STATE, 8'h40};
  logic        s_err;
  int          n_mismatch, comparisons, n_err, n_done, n_stat, cnt;

  tx_buffer_command_parser u_tx_buffer_command_parser (.ref_clk, .rst_n, .wb_adr_i, .wb_dat_i,
    .wb_dat_o, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pay_data, .pay_bytes,
    .pay_last, .pay_valid, .pay_ready, .stat_valid, .stat_tag, .stat_err, .tx_error_flag,
    .tx_buffer_done_flag, .irq);
  tx_host_model u_host (.ref_clk, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i,
    .wb_stb_i, .wb_dat_o, .wb_ack_o);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [31:0] cmd_a(logic ioc, logic [1:0] al, logic fs, logic ls,
                                        logic [10:0] n);
    return {ioc, 5'h0, al, 10'h0, fs, ls, 1'b0, n};
  endfunction

  // Error, done and status pulse counts packed for one compare
  function automatic logic [35:0] evs();
    return {12'(n_err), 12'(n_done), 12'(n_stat)};
  endfunction

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Queue the expected payload beats, load the buffer, let it drain
  task automatic send(input logic [31:0] a, input logic [31:0] b);
    int          n;
    logic [31:0] base;
    n = (int'(a[10:0]) + 3) / 4;
    base = rnd();
    for (int i = 0; i < n; i++)
      exp_q.push_back({a[12] && i == n - 1,
                       (i == n - 1 && a[1:0] != 2'h0) ? {1'b0, a[1:0]} : 3'h4, base + i});
    u_host.load(a, b, base);
    for (int i = 0; i < 50 && exp_q.size() != 0; i++) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask

  // ==========================================================================
  // Clock, stalling consumer and monitor
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    cnt <= cnt + 1;
    pay_ready <= (cnt % 5) != 3;  // Consumer stalls one cycle in five
    if (rst_n && pay_valid && pay_ready)
      check({pay_last, pay_bytes, pay_data}, exp_q.size() ? exp_q.pop_front() : ~36'h0);
    if (rst_n && stat_valid)
    begin
      s_tag = stat_tag;
      s_err = stat_err;
    end
    n_err  += rst_n && tx_error_flag;
    n_done += rst_n && tx_buffer_done_flag;
    n_stat += rst_n && stat_valid;
  end

  initial
  begin
    #400000;
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================================
  // Scenarios
  initial
  begin
    rst_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (ra[i])
    begin
      u_host.cycle(ra[i], 1'b0, 32'h0, rd_q);
      check(rd_q, 36'h0);
    end
    $display("reset values finished");
    for (int al = 0; al < 3; al++)
    begin
      sz = 11'(rnd() % 200 + 1);
      tg = 16'(rnd());
      ev0 = evs();
      send(cmd_a(1'b1, 2'(al), 1'b1, 1'b1, sz), {tg, 5'h0, sz});
      check(evs() - ev0, 36'h000_001_001);
      check({s_tag, s_err}, {tg, 1'b0});
    end
    $display("single buffers finished");
    for (int bad = 0; bad < 2; bad++)
    begin
      sz = 11'(rnd() % 60 + 1);
      s2 = 11'(rnd() % 60 + 1);
      tg = 16'(rnd());
      ev0 = evs();
      send(cmd_a(1'b1, ALIGN_32, 1'b1, 1'b0, sz), {tg, 5'h0, 11'(sz + s2)});
      send(cmd_a(1'b0, ALIGN_16, 1'b0, 1'b1, s2), {tg ^ 16'(bad), 5'h0, 11'(sz + s2)});
      check(evs() - ev0, {12'(bad), 24'h001_001});
      check({s_tag, s_err}, {tg, 1'(bad)});
    end
    $display("two buffer packets finished");
    for (int k = 0; k < 3; k++)
    begin
      sz = 11'(rnd() % 40 + 1);
      ev0 = evs();
      // Third pass leaves a packet open, then starts a new one over it
      if (k == 2)
        send(cmd_a(1'b0, ALIGN_4, 1'b1, 1'b0, sz), {16'h5A5A, 5'h0, sz});
      send(cmd_a(1'b0, (k == 1) ? ALIGN_RSV : ALIGN_4, 1'b1, 1'b1, sz),
           {16'h5A5A, 5'h0, 11'(sz + 11'(k == 0))});
      check(evs() - ev0, 36'h001_000_001);
      check(s_err, 1'b1);
    end
    $display("error packets finished");
    u_host.cycle(OFS_CLR, 1'b1, 32'h7, rd_q);
    u_host.cycle(OFS_EN, 1'b1, 32'h1, rd_q);
    send(cmd_a(1'b0, ALIGN_4, 1'b1, 1'b1, 11'h8), {16'h0001, 5'h0, 11'h8});
    check(irq, 1'b0);
    send(cmd_a(1'b1, ALIGN_4, 1'b1, 1'b1, 11'h8), {16'h0002, 5'h0, 11'h8});
    check(irq, 1'b1);
    u_host.cycle(OFS_STS, 1'b0, 32'h0, rd_q);
    check(rd_q, 36'h5);
    u_host.cycle(OFS_STATE, 1'b0, 32'h0, rd_q);
    check(rd_q, 36'h0_0002_0000);
    u_host.cycle(OFS_CLR, 1'b1, 32'h1, rd_q);
    @(posedge ref_clk);
    check(irq, 1'b0);
    $display("interrupt finished");
    tally_and_finish();
  end
endmodule // tb_tx_buffer_command_parser

//--- sim/tx_host_model.sv
// Host model that loads command words, payload and padding over Wishbone
`timescale 1ns/1ns
module tx_host_model
  import tx_cmd_pkg::*;
(
  input  wire logic             ref_clk,   // System clock
  output logic      [ADR_W-1:0] wb_adr_i,  // Byte address
  output logic      [31:0]      wb_dat_i,  // Write data
  output logic                  wb_we_i,   // Write enable
  output logic      [3:0]       wb_sel_i,  // Byte lanes
  output logic                  wb_cyc_i,  // Bus cycle
  output logic                  wb_stb_i,  // Strobe
  input  wire logic [31:0]      wb_dat_o,  // Read data
  input  wire logic             wb_ack_o   // Acknowledge
);
  // ==========================================================================
  // Idle bus at time zero
  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = SEL_FULL;
  end

  // One classic cycle, held until ack is sampled high
  task automatic cycle(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= SEL_FULL;
    wb_dat_i <= d;
    @(posedge ref_clk);
    while (wb_ack_o !== 1'b1) @(posedge ref_clk);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~d;  // Released data must not linger
  endtask

  // One buffer: both command words, payload, then padding to the boundary
  task automatic load(input logic [31:0] a, input logic [31:0] b, input logic [31:0] base);
    int          n;
    int          p;
    logic [31:0] q;
    n = (int'(a[10:0]) + 3) / 4;
    p = (a[25:24] == ALIGN_16) ? (-n & 3) : (a[25:24] == ALIGN_32) ? (-n & 7) : 0;
    cycle(OFS_DATA, 1'b1, a & ~32'h7CFF_C800, q);
    cycle(OFS_DATA, 1'b1, b, q);
    for (int i = 0; i < n; i++)
      cycle(OFS_DATA, 1'b1, base + i, q);
    for (int i = 0; i < p; i++)
      cycle(OFS_DATA, 1'b1, ~base, q);
  endtask
endmodule // tx_host_model

//--- verilog/tx_buffer_command_parser.sv
// Transmit buffer command parser with Wishbone slave and event interrupts
// How it works
// RULE1: Host writes the command words before each buffer's payload.
// RULE2: Each buffer opens with two 32-bit words, word A then word B.
// RULE3: A 16-bit packet tag is taken from command word B.
// RULE4: The tag is reported unaltered with the packet's status word.
// RULE5: Host sends both command words for every buffer of a packet.
// RULE6: Host repeats an identical word B for all buffers of a packet.
// RULE7: A word B differing from the packet's first one raises the error flag.
// RULE8: With interrupt-on-completion set, buffer-done pulses once the buffer is loaded.
// RULE9: Buffer-done can be routed to the interrupt output by an enable bit.
// RULE10: Host writes zeros into reserved bits of word A.
// RULE11: Alignment code 00, 01, 10 selects 4, 16, 32-byte end alignment.
// RULE12: Host appends padding words up to the selected alignment boundary.
// RULE13: Padding words are dropped and never leave as payload.
// RULE14: Command words and padding take no payload storage.
// RULE15: First-segment bit set starts a new packet.
// RULE16: Last-segment bit set ends the current packet.
// RULE17: Eleven-bit buffer size plus alignment locate the padding words.
// RULE18: Summed buffer sizes differing from word B's length raise the error flag.
// RULE19: Alignment code 11 is reserved; it is treated as 4-byte and flagged.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module tx_buffer_command_parser
  import tx_cmd_pkg::*;
(
  input  wire logic              ref_clk,              // System clock, 125 MHz
  input  wire logic              rst_n,                // Asynchronous reset
  input  wire logic [ADR_W-1:0]  wb_adr_i,             // Byte address
  input  wire logic [31:0]       wb_dat_i,             // Write data
  output logic      [31:0]       wb_dat_o,             // Read data
  input  wire logic              wb_we_i,              // Write enable
  input  wire logic [3:0]        wb_sel_i,             // Byte lane selects
  input  wire logic              wb_cyc_i,             // Bus cycle
  input  wire logic              wb_stb_i,             // Strobe
  output logic                   wb_ack_o,             // Acknowledge
  output logic      [31:0]       pay_data,             // Payload word
  output logic      [2:0]        pay_bytes,            // Valid bytes, low first
  output logic                   pay_last,             // Last word of packet
  output logic                   pay_valid,            // Payload word valid
  input  wire logic              pay_ready,            // Consumer takes word
  output logic                   stat_valid,           // Packet status pulse
  output logic      [TAG_W-1:0]  stat_tag,             // Packet tag
  output logic                   stat_err,             // Packet had an error
  output logic                   tx_error_flag,        // Error pulse
  output logic                   tx_buffer_done_flag,  // Buffer loaded pulse
  output logic                   irq                   // Level interrupt
);

  // ==========================================================================
  // Declarations
  logic                ack_q;
  logic [31:0]         rd_q;
  parse_state_t        st_q;
  logic [31:0]         a_q;
  logic [31:0]         b_q;
  logic                in_pkt_q;
  logic                pkt_err_q;
  logic [SUM_W-1:0]    sum_q;
  logic [WCNT_W-1:0]   words_left_q;
  logic [2:0]          pad_left_q;
  logic [2:0]          last_bytes_q;
  logic [31:0]         pay_data_q;
  logic [2:0]          pay_bytes_q;
  logic                pay_last_q;
  logic                pay_valid_q;
  logic                stat_valid_q;
  logic [TAG_W-1:0]    stat_tag_q;
  logic                stat_err_q;
  logic                err_q;
  logic                done_q;
  logic [WCNT_W-1:0]   pay_words;
  logic [2:0]          pad_words;
  logic [2:0]          last_bytes;
  logic                align_bad;
  logic [IRQ_W-1:0]    evt;
  logic [IRQ_W-1:0]    sts;
  logic [IRQ_W-1:0]    en;
  logic                req;
  logic                slot_free;
  logic                take;
  logic                dw;
  logic                w_a;
  logic                w_b;
  logic                w_pay;
  logic                w_pad;
  logic                first;
  logic                pay_end;
  logic                end_buf;
  logic                pkt_end;
  logic [31:0]         cur_b;
  logic [SUM_W-1:0]    sum_next;
  logic [SUM_W-1:0]    sum_cur;
  logic                err_b;
  logic                err_len;
  logic                err_now;

  // ==========================================================================
  // Bus decode: data writes stall while the payload slot is occupied and pay_ready is low
  assign req       = wb_cyc_i & wb_stb_i & ~ack_q;
  assign slot_free = ~pay_valid_q | pay_ready;
  assign take      = req & (~(wb_we_i && wb_adr_i == OFS_DATA) | slot_free);
  assign dw        = take & wb_we_i & (wb_adr_i == OFS_DATA) & (wb_sel_i == SEL_FULL);

  // Words routed by parser position
  assign w_a   = dw & (st_q == ST_CMD_A);  // see RULE2
  assign w_b   = dw & (st_q == ST_CMD_B);  // see RULE2
  assign w_pay = dw & (st_q == ST_PAYLOAD);
  assign w_pad = dw & (st_q == ST_PAD);    // see RULE13

  // Packet bookkeeping terms
  assign first    = a_q[A_FS];                                   // see RULE15
  assign pay_end  = w_pay & (words_left_q == 10'h001);
  assign end_buf  = (w_b & (pay_words == '0) & (pad_words == '0))
                  | (pay_end & (pad_left_q == '0))
                  | (w_pad & (pad_left_q == 3'h1));
  assign pkt_end  = end_buf & a_q[A_LS];                         // see RULE16
  assign cur_b    = (w_b & first) ? wb_dat_i : b_q;
  assign sum_next = first ? SUM_W'(size_of(a_q))
                          : sum_q + SUM_W'(size_of(a_q));        // see RULE18
  assign sum_cur  = w_b ? sum_next : sum_q;

  // Error terms: misplaced segment, word B mismatch, reserved alignment, length mismatch
  assign err_b    = w_b & (align_bad                             // see RULE19
                  | (first & in_pkt_q)
                  | (~first & ~in_pkt_q)
                  | (~first & in_pkt_q & (wb_dat_i != b_q)));    // see RULE7
  assign err_len  = pkt_end & (sum_cur != len_of(cur_b));        // see RULE18
  assign err_now  = err_b | err_len;

  // ==========================================================================
  // Buffer size and alignment arithmetic
  tx_pad_calc u_calc (
    .size       (size_of(a_q)),
    .align      (a_q[A_ALIGN_LO +: 2]),
    .pay_words  (pay_words),
    .pad_words  (pad_words),
    .last_bytes (last_bytes),
    .align_bad  (align_bad)
  );

  // ==========================================================================
  // Wishbone answer: one-cycle ack and registered read data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= take;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_q <= '0;
    else if (take)
    begin
      unique case (wb_adr_i)
        OFS_STS:   rd_q <= {29'h0, sts};
        OFS_EN:    rd_q <= {29'h0, en};
        OFS_STATE: rd_q <= {stat_tag_q, 13'h0, in_pkt_q, st_q};
        default:   rd_q <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Parser position across command, payload and padding words
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= ST_CMD_A;
    else if (w_a)
      st_q <= ST_CMD_B;                                          // see RULE2
    else if (w_b)
    begin
      if (pay_words != '0)
        st_q <= ST_PAYLOAD;
      else if (pad_words != '0)
        st_q <= ST_PAD;
      else
        st_q <= ST_CMD_A;
    end
    else if (pay_end)
      st_q <= (pad_left_q != '0) ? ST_PAD : ST_CMD_A;            // see RULE13
    else if (w_pad && pad_left_q == 3'h1)
      st_q <= ST_CMD_A;
  end

  // Command word A and word counters
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_q          <= '0;
      words_left_q <= '0;
      pad_left_q   <= '0;
      last_bytes_q <= '0;
    end
    else if (w_a)
      a_q <= wb_dat_i;
    else if (w_b)
    begin
      words_left_q <= pay_words;                                 // see RULE17
      pad_left_q   <= pad_words;                                 // see RULE11
      last_bytes_q <= last_bytes;
    end
    else if (w_pay)
      words_left_q <= words_left_q - 10'h001;
    else if (w_pad)
      pad_left_q <= pad_left_q - 3'h1;                           // see RULE13
  end

  // Packet state: reference word B, running size sum, error collection
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_q       <= '0;
      sum_q     <= '0;
      in_pkt_q  <= 1'b0;
      pkt_err_q <= 1'b0;
    end
    else
    begin
      if (w_b && first)
        b_q <= wb_dat_i;                                         // see RULE15
      if (w_b)
        sum_q <= sum_next;                                       // see RULE18
      if (pkt_end)
        in_pkt_q <= 1'b0;                                        // see RULE16
      else if (w_b)
        in_pkt_q <= 1'b1;
      if (pkt_end)
        pkt_err_q <= 1'b0;
      else if (w_b && first)
        pkt_err_q <= err_now;
      else if (err_now)
        pkt_err_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Payload slot: only payload words are stored, commands and padding are not
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pay_valid_q <= 1'b0;
      pay_data_q  <= '0;
      pay_bytes_q <= '0;
      pay_last_q  <= 1'b0;
    end
    else if (w_pay)
    begin
      pay_valid_q <= 1'b1;                                       // see RULE14
      pay_data_q  <= wb_dat_i;
      pay_bytes_q <= (words_left_q == 10'h001) ? last_bytes_q : BYTES_FULL;
      pay_last_q  <= (words_left_q == 10'h001) & a_q[A_LS];
    end
    else if (pay_ready)
      pay_valid_q <= 1'b0;
  end

  // Status word, error and buffer-done pulses
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_valid_q <= 1'b0;
      stat_tag_q   <= '0;
      stat_err_q   <= 1'b0;
      err_q        <= 1'b0;
      done_q       <= 1'b0;
    end
    else
    begin
      stat_valid_q <= pkt_end;
      if (pkt_end)
      begin
        stat_tag_q <= tag_of(cur_b);                             // see RULE3
        stat_err_q <= err_now | (pkt_err_q & ~(w_b & first));    // see RULE4
      end
      err_q  <= err_now;                                         // see RULE7
      done_q <= end_buf & a_q[A_IOC];                            // see RULE8
    end
  end

  // ==========================================================================
  // Event status and interrupt routing
  always_comb
  begin
    evt           = '0;
    evt[IRQ_DONE] = done_q;
    evt[IRQ_ERR]  = err_q;
    evt[IRQ_STAT] = stat_valid_q;
  end

  tx_irq_status u_irq (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .evt     (evt),
    .clr_wr  (take & wb_we_i & (wb_adr_i == OFS_CLR) & wb_sel_i[0]),
    .en_wr   (take & wb_we_i & (wb_adr_i == OFS_EN) & wb_sel_i[0]),
    .wdata   (wb_dat_i[IRQ_W-1:0]),
    .sts_q   (sts),
    .en_q    (en),
    .irq     (irq)                                               // see RULE9
  );

  // Output drive
  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = rd_q;
  assign pay_data            = pay_data_q;
  assign pay_bytes           = pay_bytes_q;
  assign pay_last            = pay_last_q;
  assign pay_valid           = pay_valid_q;
  assign stat_valid          = stat_valid_q;
  assign stat_tag            = stat_tag_q;
  assign stat_err            = stat_err_q;
  assign tx_error_flag       = err_q;
  assign tx_buffer_done_flag = done_q;

  // ==========================================================================
  // Assertions
  a_cmd_order: // see RULE2
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      w_a |=> st_q == ST_CMD_B && a_q == $past(wb_dat_i))
    else $error("word A not followed by word B position");

  a_tag_copied: // see RULE4
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      pkt_end |=> stat_valid_q && stat_tag_q == tag_of($past(cur_b)))
    else $error("status tag differs from word B tag");

  a_b_mismatch: // see RULE7
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (w_b && !first && in_pkt_q && wb_dat_i != b_q) |=> tx_error_flag)
    else $error("word B mismatch not flagged");

  a_done_cause: // see RULE8
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_buffer_done_flag |-> $past(end_buf) && $past(a_q[A_IOC]))
    else $error("buffer done without completed flagged buffer");

  a_irq_route: // see RULE9
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      tx_buffer_done_flag && en[IRQ_DONE] |=> irq)
    else $error("enabled buffer done not on interrupt");

  a_align16_pad: // see RULE11
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (w_b && a_q[A_ALIGN_LO +: 2] == ALIGN_16)
      |=> ((words_left_q + WCNT_W'(pad_left_q)) & 10'h003) == 10'h000)
    else $error("16-byte alignment padding miscounted");

  a_pad_dropped: // see RULE13
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (w_pad || w_a || w_b) |=> !pay_valid_q)
    else $error("non-payload word reached payload output");

  a_first_seg: // see RULE15
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (w_b && first) |=> sum_q == SUM_W'(size_of($past(a_q))))
    else $error("first segment did not restart size sum");

  a_last_seg: // see RULE16
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      pkt_end |=> !in_pkt_q ##1 !stat_valid_q)
    else $error("last segment did not close packet");

  a_len_check: // see RULE18
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      err_len |=> tx_error_flag && stat_err)
    else $error("length mismatch not flagged");

  a_align_rsv: // see RULE19
    assert property (@(posedge ref_clk) disable iff (!rst_n)
      (w_b && a_q[A_ALIGN_LO +: 2] == ALIGN_RSV) |=> tx_error_flag)
    else $error("reserved alignment not flagged");

endmodule // tx_buffer_command_parser

//--- verilog/tx_cmd_pkg.sv
// Constants, field layouts and types shared by the transmit command parser
package tx_cmd_pkg;

  // ==========================================================================
  // Register map, byte addresses on the Wishbone slave
  localparam int         ADR_W      = 8;
  localparam logic [7:0] OFS_DATA   = 8'h00;  // Write: next transmit FIFO word
  localparam logic [7:0] OFS_STS    = 8'h04;  // Read: sticky event status
  localparam logic [7:0] OFS_CLR    = 8'h08;  // Write: one clears status bit
  localparam logic [7:0] OFS_EN     = 8'h0C;  // Read/write: interrupt enables
  localparam logic [7:0] OFS_STATE  = 8'h10;  // Read: parser state and last tag
  localparam logic [3:0] SEL_FULL   = 4'hF;

  // ==========================================================================
  // Event bits, same layout in status, clear and enable
  localparam int         IRQ_W      = 3;
  localparam int         IRQ_DONE   = 0;
  localparam int         IRQ_ERR    = 1;
  localparam int         IRQ_STAT   = 2;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // ==========================================================================
  // Command word A fields
  localparam int         A_IOC      = 31;
  localparam int         A_ALIGN_LO = 24;
  localparam int         A_FS       = 13;
  localparam int         A_LS       = 12;
  localparam int         SIZE_W     = 11;
  localparam logic [1:0] ALIGN_4    = 2'h0;
  localparam logic [1:0] ALIGN_16   = 2'h1;
  localparam logic [1:0] ALIGN_32   = 2'h2;
  localparam logic [1:0] ALIGN_RSV  = 2'h3;

  // ==========================================================================
  // Command word B fields, counts and widths
  localparam int         B_TAG_LO   = 16;
  localparam int         TAG_W      = 16;
  localparam int         SUM_W      = 16;
  localparam int         WCNT_W     = 10;
  localparam logic [2:0] BYTES_FULL = 3'h4;

  typedef enum logic [1:0] {ST_CMD_A, ST_CMD_B, ST_PAYLOAD, ST_PAD} parse_state_t;

  // Byte count of the buffer from command word A
  function automatic logic [SIZE_W-1:0] size_of(input logic [31:0] w);
    return w[SIZE_W-1:0];
  endfunction

  // Packet tag from command word B
  function automatic logic [TAG_W-1:0] tag_of(input logic [31:0] w);
    return w[B_TAG_LO +: TAG_W];
  endfunction

  // Packet length from command word B, widened to the running sum
  function automatic logic [SUM_W-1:0] len_of(input logic [31:0] w);
    return {{(SUM_W-SIZE_W){1'b0}}, w[SIZE_W-1:0]};
  endfunction

endpackage

//--- verilog/tx_irq_status.sv
// Sticky event status, write-one-to-clear, enable mask and interrupt level
`timescale 1ns/1ns
module tx_irq_status
  import tx_cmd_pkg::*;
(
  input  wire logic             ref_clk,   // System clock
  input  wire logic             rst_n,     // Asynchronous reset, active low
  input  wire logic [IRQ_W-1:0] evt,       // Event pulses
  input  wire logic             clr_wr,    // Clear register write strobe
  input  wire logic             en_wr,     // Enable register write strobe
  input  wire logic [IRQ_W-1:0] wdata,     // Write data
  output logic      [IRQ_W-1:0] sts_q,     // Sticky status
  output logic      [IRQ_W-1:0] en_q,      // Interrupt enables
  output logic                  irq        // Level interrupt
);

  // Status bits: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sts_q <= '0;
    else
      sts_q <= (sts_q & ~(clr_wr ? wdata : '0)) | evt;
  end

  // Enable register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_q <= IRQ_EN_RST;
    else if (en_wr)
      en_q <= wdata;
  end

  assign irq = |(sts_q & en_q);

endmodule // tx_irq_status

//--- verilog/tx_pad_calc.sv
// Payload and padding word counts of one buffer
`timescale 1ns/1ns
module tx_pad_calc
  import tx_cmd_pkg::*;
(
  input  wire logic [SIZE_W-1:0] size,        // Buffer byte count
  input  wire logic [1:0]        align,       // End alignment code
  output logic      [WCNT_W-1:0] pay_words,   // Words carrying payload
  output logic      [2:0]        pad_words,   // Padding words to drop
  output logic      [2:0]        last_bytes,  // Valid bytes in final word
  output logic                   align_bad    // Reserved alignment code
);

  logic [SIZE_W:0] rounded;
  logic [2:0]      mask;
  logic [2:0]      rem;

  // Round bytes up to words, then pad words up to the alignment group
  always_comb
  begin
    rounded    = {1'b0, size} + 12'h003;
    pay_words  = rounded[SIZE_W:2];
    last_bytes = (size[1:0] == 2'h0) ? BYTES_FULL : {1'b0, size[1:0]};
    align_bad  = (align == ALIGN_RSV);
    unique case (align)
      ALIGN_16: mask = 3'h3;
      ALIGN_32: mask = 3'h7;
      default:  mask = 3'h0;
    endcase
    rem        = pay_words[2:0] & mask;
    pad_words  = (3'h0 - rem) & mask;
  end

endmodule // tx_pad_calc
